// *** design/nand_host.sv ***
// NAND flash host controller: sequences commands, addresses and data on the flash pins.
// Assumes one flash device; io_bus and ready/busy come from pins, write data from user logic.
module nand_host
  import nand_host_pkg::*;
#(
  parameter int unsigned TR_TIMEOUT = nand_host_pkg::TR_CYC * 4000
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_ce,
  input  wire nand_host_pkg::req_s   i_req,
  input  wire logic                  i_req_valid,
  output logic                       o_req_ready,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [7:0]                 o_rdata,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic                       o_done,
  output logic                       o_timeout,
  output nand_host_pkg::pins_s       o_pins,
  output logic                       o_wp_n,
  output logic [7:0]                 o_io_bus,
  output logic                       o_io_bus_oe,
  input  wire logic [7:0]            i_io_bus,
  input  wire logic                  i_ready_busy_n
);
  import nand_host_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_CMD1  = 4'h1,
    ST_ADDR  = 4'h3,
    ST_DIN   = 4'h2,
    ST_CMD2  = 4'h6,
    ST_WAIT  = 4'h7,
    ST_DOUT  = 4'h5,
    ST_DONE  = 4'h4
  } st_e;

  // Step of a pin write cycle: 0 set up, 1 strobe low, 2 strobe high.
  st_e         st_q;
  logic [1:0]  ph_q;
  logic [7:0]  pcnt_q;
  logic [2:0]  acnt_q;
  logic [11:0] bcnt_q;
  req_s        req_q;
  logic        pass2_q;
  logic [31:0] wcnt_q;
  logic [1:0]  rb_sync_q;
  logic [7:0]  io_s1_q;
  logic [7:0]  io_s2_q;
  logic        rb;

  // Two-entry read buffer.
  logic [7:0]  buf_q [2];
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [1:0]  cnt_q;
  logic        buf_push;
  logic        buf_pop;

  assign rb = rb_sync_q[1];

  // First command byte for an operation.
  function automatic logic [7:0] first_cmd(input op_e op, input logic second);
    unique case (op)
      OP_READ:   first_cmd = CMD_READ1;
      OP_PROG:   first_cmd = CMD_PROG1;
      OP_CACHE:  first_cmd = CMD_PROG1;
      OP_ERASE:  first_cmd = CMD_ERASE1;
      OP_COPY:   first_cmd = second ? CMD_COPY1 : CMD_READ1;
      OP_ID:     first_cmd = CMD_READ_ID;
      OP_STATUS: first_cmd = CMD_STATUS;
      OP_RESET:  first_cmd = CMD_RESET;
    endcase
  endfunction : first_cmd

  // Closing command byte for an operation.
  function automatic logic [7:0] last_cmd(input op_e op, input logic second);
    unique case (op)
      OP_READ:  last_cmd = CMD_READ2;
      OP_CACHE: last_cmd = CMD_CACHE2;
      OP_ERASE: last_cmd = CMD_ERASE2;
      OP_COPY:  last_cmd = second ? CMD_PROG2 : CMD_READ_CB;
      default:  last_cmd = CMD_PROG2;
    endcase
  endfunction : last_cmd

  // Address byte n of the five cycles; erase sends row bytes only.
  function automatic logic [7:0] addr_byte(input logic [28:0] a, input logic [2:0] n);
    unique case (n)
      3'h0:    addr_byte = a[7:0];
      3'h1:    addr_byte = {4'h0, a[11:8]};
      3'h2:    addr_byte = a[19:12];
      3'h3:    addr_byte = a[27:20];
      default: addr_byte = {7'h00, a[28]};
    endcase
  endfunction : addr_byte

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Ready/busy and the bus pass two flops before use.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rb_sync_q <= 2'h0;
      io_s1_q   <= 8'h00;
      io_s2_q   <= 8'h00;
    end else if (i_ce) begin
      rb_sync_q <= {rb_sync_q[0], i_ready_busy_n};
      io_s1_q   <= i_io_bus;
      io_s2_q   <= io_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic op_has_addr;
  logic op_has_din;
  logic op_has_cmd2;
  logic op_has_dout;
  logic op_waits;
  logic phase_end;
  logic [2:0] addr_last;
  assign op_has_addr = (req_q.op != OP_STATUS) && (req_q.op != OP_RESET);
  assign op_has_din  = (req_q.op == OP_PROG) || (req_q.op == OP_CACHE);
  assign op_has_cmd2 = op_has_addr && (req_q.op != OP_ID);
  assign op_has_dout = (req_q.op == OP_READ) || (req_q.op == OP_ID) ||
                       (req_q.op == OP_STATUS);
  assign op_waits    = (req_q.op != OP_ID) && (req_q.op != OP_STATUS);
  assign phase_end   = (pcnt_q == 8'(PHASE_CYC - 1));
  assign addr_last   = (req_q.op == OP_ERASE) ? 3'h2 :
                       (req_q.op == OP_ID) ? 3'h0 : 3'(ADDR_CYCLES - 1);
  assign buf_push    = (st_q == ST_DOUT) && (ph_q == 2'h2) && phase_end;

  // Main sequence; each byte is setup, strobe low, strobe high phases.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q    <= ST_IDLE;
      ph_q    <= 2'h0;
      pcnt_q  <= 8'h00;
      acnt_q  <= 3'h0;
      bcnt_q  <= 12'h000;
      pass2_q <= 1'b0;
      wcnt_q  <= 32'h0000_0000;
      req_q   <= '0;
      o_done  <= 1'b0;
      o_timeout <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (st_q == ST_IDLE) begin
        if (i_req_valid) begin
          req_q   <= i_req;
          pass2_q <= 1'b0;
          st_q    <= ST_CMD1;
          ph_q    <= 2'h0;
          pcnt_q  <= 8'h00;
          o_timeout <= 1'b0;
        end
      end else if (st_q == ST_WAIT) begin
        // Hold off until ready returns, ignoring the first busy-rise window.
        wcnt_q <= wcnt_q + 32'h0000_0001;
        if ((wcnt_q >= 32'(WAIT_BUSY_CYC) && rb) || wcnt_q >= TR_TIMEOUT) begin
          o_timeout <= !rb;
          wcnt_q    <= 32'h0000_0000;
          if (req_q.op == OP_COPY && !pass2_q) begin
            pass2_q <= 1'b1;
            st_q    <= ST_CMD1;
          end else begin
            st_q <= op_has_dout ? ST_DOUT : ST_DONE;
          end
          bcnt_q <= 12'h000;
        end
      end else if (st_q == ST_DONE) begin
        o_done <= 1'b1;
        st_q   <= ST_IDLE;
      end else if (!(ph_q == 2'h0 && ((st_q == ST_DIN && !i_wvalid) ||
                                    (st_q == ST_DOUT && cnt_q == 2'h2)))) begin
        // Data-in stalls for user data; data-out stalls when the buffer is full.
        pcnt_q <= phase_end ? 8'h00 : pcnt_q + 8'h01;
        if (phase_end) begin
          ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
          if (ph_q == 2'h2) begin
            unique case (st_q)
              ST_CMD1: begin
                acnt_q <= (req_q.op == OP_ERASE) ? 3'h0 : 3'h0;
                if (op_has_addr) st_q <= ST_ADDR;
                else if (op_has_dout) st_q <= ST_DOUT;
                else st_q <= ST_WAIT;
                bcnt_q <= 12'h000;
              end
              ST_ADDR: begin
                acnt_q <= acnt_q + 3'h1;
                if (acnt_q == addr_last) begin
                  if (op_has_din && !pass2_q) st_q <= ST_DIN;
                  else if (op_has_cmd2) st_q <= ST_CMD2;
                  else st_q <= ST_DOUT;
                end
              end
              ST_DIN: begin
                bcnt_q <= bcnt_q + 12'h001;
                if (bcnt_q == req_q.len - 12'h001) st_q <= ST_CMD2;
              end
              ST_CMD2: st_q <= ST_WAIT;
              ST_DOUT: begin
                bcnt_q <= bcnt_q + 12'h001;
                if (bcnt_q == req_q.len - 12'h001) st_q <= ST_DONE;
              end
              default: st_q <= ST_IDLE;
            endcase
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Strobes, latches and bus drive come straight from flops.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pins      <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1};
      o_io_bus    <= 8'h00;
      o_io_bus_oe <= 1'b0;
      o_wp_n      <= 1'b0;
    end else if (i_ce) begin
      o_wp_n             <= 1'b1;
      o_pins.ce_n        <= (st_q == ST_IDLE) || (st_q == ST_DONE);
      o_pins.cle         <= (st_q == ST_CMD1) || (st_q == ST_CMD2);
      o_pins.ale         <= (st_q == ST_ADDR);
      o_pins.we_n        <= !((ph_q == 2'h1) && (st_q inside {ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2}));
      o_pins.read_strobe_n <= !((ph_q == 2'h1) && (st_q == ST_DOUT));
      o_io_bus_oe        <= st_q inside {ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2};
      unique case (st_q)
        ST_CMD1: o_io_bus <= first_cmd(req_q.op, pass2_q);
        ST_CMD2: o_io_bus <= last_cmd(req_q.op, pass2_q);
        ST_ADDR: o_io_bus <= addr_byte(pass2_q ? req_q.dst : req_q.addr, acnt_q + ((req_q.op == OP_ERASE) ? 3'h2 : 3'h0));
        ST_DIN: begin
          // Load only in the set-up phase, so the byte stands through the strobe rise.
          if (ph_q == 2'h0) o_io_bus <= i_wdata;
        end
        default: o_io_bus <= 8'h00;
      endcase
    end
  end

  // Write data handshake: a byte is taken as its write strobe falls.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wready    <= 1'b0;
      o_req_ready <= 1'b0;
    end else if (i_ce) begin
      o_wready    <= (st_q == ST_DIN) && (ph_q == 2'h1) && (pcnt_q == 8'(PHASE_CYC - 2));
      o_req_ready <= (st_q == ST_IDLE) && !i_req_valid;
    end
  end

  // ----------------------------------------------------------------
  // Read buffer
  // ----------------------------------------------------------------
  assign buf_pop = o_rvalid && i_rready;

  // Head pointer after this cycle; the output register must show that entry.
  logic rd_next;
  assign rd_next = rd_ptr_q ^ buf_pop;

  // Two-entry buffer so a stalled consumer loses no byte.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
      o_rvalid <= 1'b0;
      o_rdata  <= 8'h00;
    end else if (i_ce) begin
      if (buf_push) begin
        buf_q[wr_ptr_q] <= io_s2_q;
        wr_ptr_q        <= !wr_ptr_q;
      end
      if (buf_pop) rd_ptr_q <= !rd_ptr_q;
      cnt_q    <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      o_rvalid <= (cnt_q + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'h0;
      o_rdata  <= (buf_push && (rd_next == wr_ptr_q)) ? io_s2_q : buf_q[rd_next];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cmd_strobe;
    o_pins.cle && !o_pins.ale && !o_pins.we_n;
  endsequence

  AST_CMD_LATCH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_cmd_strobe |-> o_pins.read_strobe_n && !o_pins.ce_n && o_io_bus_oe)
    else $error("Command strobe without proper latch and select levels.");
  AST_NO_BOTH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(o_io_bus_oe && !o_pins.read_strobe_n))
    else $error("Bus driven while the read strobe is low.");
  AST_ADDR_LATCH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_pins.ale && !o_pins.we_n) |-> !o_pins.cle && o_io_bus_oe)
    else $error("Address strobe with command latch high.");
  AST_WE_STABLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && $rose(o_pins.we_n)) |-> $stable(o_io_bus))
    else $error("Bus changed on the write strobe rise.");
  AST_WP_HIGH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_pins.cle && o_io_bus == CMD_PROG2) |-> o_wp_n)
    else $error("Program confirm issued with write protect low.");
  AST_RD_WIDTH: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && $fell(o_pins.read_strobe_n)) |=> !o_pins.read_strobe_n)
    else $error("Read strobe low phase too short.");
  AST_WAIT_RB: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_q == ST_WAIT && i_ce && !rb && wcnt_q < TR_TIMEOUT) |=> st_q == ST_WAIT)
    else $error("Left the wait while the flash was busy.");
  AST_BUF_FULL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cnt_q != 2'h3)
    else $error("Read buffer overflow.");

endmodule : nand_host

// *** design/nand_host_pkg.sv ***
// Package for the NAND flash host controller: commands, geometry, timing and carriers.
// Assumes a 100 MHz system clock and one byte-wide flash device on the pins.
//
// Function
// - Command latch high at the write strobe rise loads a command byte.
// - Address latch high at the write strobe rise loads an address byte.
// - One bus carries command, address and data both ways, time multiplexed.
// - Open-drain ready/busy lines of several memories may be wired together.
// - After transfer, bytes read out with read strobe cycles of at least 30 ns.
// - Command byte goes with select low, command high, address low, read high.
// - The host sends the 29-bit array address as five address cycles; erase sends three row cycles and read ID one cycle.
// - Page read is 00h, five addresses, 30h, then wait for ready.
package nand_host_pkg;

  // Command codes.
  localparam logic [7:0] CMD_READ1     = 8'h00;
  localparam logic [7:0] CMD_READ2     = 8'h30;
  localparam logic [7:0] CMD_READ_CB   = 8'h35;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_PROG1     = 8'h80;
  localparam logic [7:0] CMD_PROG2     = 8'h10;
  localparam logic [7:0] CMD_CACHE2    = 8'h15;
  localparam logic [7:0] CMD_COPY1     = 8'h85;
  localparam logic [7:0] CMD_ERASE1    = 8'h60;
  localparam logic [7:0] CMD_ERASE2    = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;

  // Geometry.
  localparam int unsigned PAGE_BYTES      = 2112;
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned NUM_BLOCKS      = 4096;
  localparam int unsigned ADDR_CYCLES     = 5;
  localparam int unsigned ID_BYTES        = 2;
  localparam int unsigned ADDR_BITS       = 29;

  // Timing: clock period and pin phase lengths.
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned RD_CYCLE_NS   = 30;
  localparam int unsigned PHASE_CYC     = (RD_CYCLE_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int unsigned WAIT_BUSY_NS  = 100;
  localparam int unsigned WAIT_BUSY_CYC = (WAIT_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TR_US         = 25;
  localparam int unsigned TR_CYC        = TR_US * 1000 / CLK_NS;

  // Operation selector.
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_PROG   = 3'h1,
    OP_CACHE  = 3'h2,
    OP_ERASE  = 3'h3,
    OP_COPY   = 3'h4,
    OP_ID     = 3'h5,
    OP_STATUS = 3'h6,
    OP_RESET  = 3'h7
  } op_e;

  // Request from the user side.
  typedef struct packed {
    op_e              op;
    logic [28:0]      addr;
    logic [28:0]      dst;
    logic [11:0]      len;
  } req_s;

  // Flash pin bundle driven by the controller.
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
  } pins_s;

endpackage : nand_host_pkg

// *** verif/nand_flash_model.sv ***
// Behavioural byte-wide flash device facing the host controller pins.
// Assumes the bench resolves the shared bus and pulls the ready/busy line up.
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter int unsigned BUSY_NS = 400,
  parameter logic [7:0]  MAKER   = 8'h5A, // Arbitrary value.
  parameter logic [7:0]  PART    = 8'hC3  // Arbitrary value.
) (
  input  wire nand_host_pkg::pins_s i_pins,
  input  wire logic                 i_wp_n,
  input  wire logic [7:0]           i_dq,
  output logic [7:0]                o_dq,
  output logic                      o_rb_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] arr [longint];
  logic [7:0] pbuf [int];
  logic [7:0] a [5];
  logic [7:0] cmd = 8'h00;
  logic [7:0] dreg = 8'h00;
  int acnt = 0;
  int col = 0;
  int idn = 0;
  longint row = 0;
  initial o_rb_low = 1'b0;
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign o_dq = (!i_pins.ce_n && !i_pins.read_strobe_n) ? dreg : ~dreg;
  // Busy window; the host side may not start another array operation meanwhile.
  task automatic busy_for(input int ns);
    o_rb_low = 1'b1;
    #(ns);
    o_rb_low = 1'b0;
  endtask : busy_for
  // Only the rising write strobe latches the bus, steered by the latch strobes.
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && i_pins.cle) begin
      cmd = i_dq;
      acnt = 0;
      case (i_dq)
        CMD_READ2: busy_for(BUSY_NS);
        CMD_READ_ID: idn = 0;
        CMD_PROG1: pbuf.delete();
        CMD_READ_CB: begin
          pbuf.delete();
          for (int c = 0; c < PAGE_BYTES; c++) begin
            if (arr.exists(row * 4096 + c)) pbuf[c] = arr[row * 4096 + c];
          end
          busy_for(BUSY_NS);
        end
        CMD_PROG2, CMD_CACHE2: begin
          if (i_wp_n) begin
            foreach (pbuf[c]) arr[row * 4096 + c] = pbuf[c];
            busy_for(BUSY_NS);
          end
        end
        CMD_ERASE2: begin
          if (i_wp_n) begin
            for (int p = 0; p < PAGES_PER_BLOCK; p++) begin
              for (int c = 0; c < PAGE_BYTES; c++) arr.delete(((row / 64) * 64 + p) * 4096 + c);
            end
            busy_for(BUSY_NS);
          end
        end
        default: acnt = 0;
      endcase
    end else if (!i_pins.ce_n && i_pins.ale) begin
      a[acnt] = i_dq;
      acnt++;
      if (cmd == CMD_ERASE1) row = {a[2][0], a[1], a[0]};
      else begin
        col = {a[1][3:0], a[0]};
        row = {a[4][0], a[3], a[2]};
      end
    end else if (!i_pins.ce_n) begin
      pbuf[col] = i_dq;
      col++;
    end
  end
  // Each falling read strobe presents the next byte; select toggles keep the pointer.
  always @(negedge i_pins.read_strobe_n) begin
    if (!i_pins.ce_n) begin
      if (cmd == CMD_READ_ID) dreg = (idn == 0) ? MAKER : PART;
      else dreg = arr.exists(row * 4096 + col) ? arr[row * 4096 + col] : 8'hFF;
      idn++;
      col++;
    end
  end
endmodule : nand_flash_model

// *** verif/nand_host_tb.sv ***
// Self-checking bench for the host controller against the behavioural flash model.
// Assumes a 100 MHz clock; the ready/busy line has a pull-up.
module nand_host_tb
  import nand_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0]  PART  = 8'hC3; // Arbitrary value.
  localparam logic [28:0] SRC   = {17'h0_0041, 12'h083C};
  localparam logic [28:0] DST   = {17'h0_0083, 12'h083C};
  logic i_clk = 1'b0, i_sys_rst = 1'b1, req_valid = 1'b0, wvalid = 1'b0, rready = 1'b0;
  logic [7:0] wdata = 8'h00, rdata, io_host, io_lvl, flash_dq;
  logic req_ready, wready, rvalid, done, tmo, wp_n, io_oe, rb_low;
  logic [31:0] seed = 32'h0000_6F2E;
  logic [7:0] expq [$];
  req_s req = '0;
  pins_s pins;
  int err_total = 0, check_count = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  // Bus resolution: the host wins when it drives, else the flash level.
  assign io_lvl = io_oe ? io_host : flash_dq;
  nand_host #(.TR_TIMEOUT(200)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
    .i_req(req), .i_req_valid(req_valid), .o_req_ready(req_ready), .i_wdata(wdata),
    .i_wvalid(wvalid), .o_wready(wready), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_rready(rready), .o_done(done), .o_timeout(tmo), .o_pins(pins), .o_wp_n(wp_n),
    .o_io_bus(io_host), .o_io_bus_oe(io_oe), .i_io_bus(io_lvl), .i_ready_busy_n(~rb_low));
  nand_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.i_pins(pins), .i_wp_n(wp_n),
    .i_dq(io_lvl), .o_dq(flash_dq), .o_rb_low(rb_low));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Random receiver stalls and the shared random stream; also the hang limit.
  always @(posedge i_clk) begin
    seed <= xs(seed);
    rready <= seed[0] | seed[1];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // Every accepted read byte is matched against the oldest note.
  always @(posedge i_clk) begin
    if (!i_sys_rst && rvalid === 1'b1 && rready) begin
      if (expq.size() == 0) check("unexpected rdata", 8'h00, 8'hxx);
      else check("rdata", expq.pop_front(), rdata);
    end
  end
  // One request pulsed for a cycle, then waited on until done, with write bytes handed over on each wready.
  task automatic run_op(input op_e op, input logic [28:0] ad, input logic [28:0] ds,
                        input logic [7:0] wb [$], input logic [11:0] len);
    int n;
    int w;
    n = 0;
    w = 0;
    @(posedge i_clk);
    check("req_ready", 8'h01, {7'h00, req_ready});
    req <= '{op, ad, ds, len};
    req_valid <= 1'b1;
    wvalid <= (wb.size() > 0);
    if (wb.size() > 0) wdata <= wb[0];
    while (done !== 1'b1 && n < 2000) begin
      @(posedge i_clk);
      n++;
      // The request is taken at the first edge; holding it would start the operation again.
      req_valid <= 1'b0;
      if (wready === 1'b1 && w < wb.size()) begin
        w++;
        if (w < wb.size()) wdata <= wb[w];
        else wvalid <= 1'b0;
      end
    end
    check("done", 8'h01, {7'h00, done});
    check("timeout", 8'h00, {7'h00, tmo});
  endtask : run_op
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] pat [$];
    logic [7:0] non [$];
    repeat (5) @(posedge i_clk);
    check("wp_n in reset", 8'h00, {7'h00, wp_n});
    check("ce_n in reset", 8'h01, {7'h00, pins.ce_n});
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    run_op(OP_RESET, '0, '0, non, 12'h000);
    for (int i = 0; i < 4; i++) pat.push_back(8'(xs(seed + i)));
    run_op(OP_PROG, SRC, '0, pat, 12'h004);
    check("wp_n after reset", 8'h01, {7'h00, wp_n});
    foreach (pat[i]) expq.push_back(pat[i]);
    run_op(OP_READ, SRC, '0, non, 12'h004);
    run_op(OP_COPY, SRC, DST, non, 12'h004);
    foreach (pat[i]) expq.push_back(pat[i]);
    run_op(OP_READ, DST, '0, non, 12'h004);
    run_op(OP_ERASE, DST, '0, non, 12'h004);
    repeat (4) expq.push_back(8'hFF);
    run_op(OP_READ, DST, '0, non, 12'h004);
    foreach (pat[i]) pat[i] = ~pat[i];
    run_op(OP_CACHE, SRC + 29'h0000_1000, '0, pat, 12'h004);
    foreach (pat[i]) expq.push_back(pat[i]);
    run_op(OP_READ, SRC + 29'h0000_1000, '0, non, 12'h004);
    expq.push_back(MAKER);
    expq.push_back(PART);
    run_op(OP_ID, '0, '0, non, 12'h002);
    repeat (50) @(posedge i_clk);
    check("bytes left unread", 8'h00, 8'(expq.size()));
    end_of_test();
  end
endmodule : nand_host_tb
